// *** design/eis_pkg.sv ***
// Constants, types and state layout of the extended instruction executor
//==========================================================================
package eis_pkg;

   //=======================================================================
   // Widths, last program page and reset values
   localparam int unsigned DAW       = 12;
   localparam int unsigned PAW       = 16;
   localparam int unsigned PWW       = 16;
   localparam logic [7:0]  LAST_PAGE = 8'hff;
   localparam logic [7:0]  ACC_RST   = 8'h00;
   localparam logic [7:0]  PTR_RST   = 8'h00;
   localparam logic        Z_RST     = 1'h0;

   //=======================================================================
   // Instruction, state and load select codes
   typedef enum logic [3:0] {
      OP_SWAP   = 4'h0,
      OP_SWAPA  = 4'h1,
      OP_SZ     = 4'h2,
      OP_SZA    = 4'h3,
      OP_SZBIT  = 4'h4,
      OP_TRD    = 4'h5,
      OP_TRDL   = 4'h6,
      OP_ITRD   = 4'h7,
      OP_ITRDL  = 4'h8,
      OP_XOR    = 4'h9,
      OP_XORM   = 4'ha
   } eis_op_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_RDM   = 3'h1,
      ST_EXE   = 3'h2,
      ST_PRD   = 3'h3,
      ST_PWB   = 3'h4,
      ST_DUMMY = 3'h5
   } eis_state_t;

   typedef enum logic [1:0] {
      LD_ACC  = 2'h0,
      LD_TABLE_POINTER_LOWER = 2'h1,
      LD_TABLE_POINTER_UPPER = 2'h2
   } eis_ld_t;

   //=======================================================================
   // Whole state of the executor
   typedef struct packed {
      eis_state_t       st;
      eis_op_t          op;
      logic [DAW-1:0]   addr;
      logic [2:0]       bsel;
      logic [7:0]       acc;
      logic             z;
      logic [7:0]       table_pointer_lower;
      logic [7:0]       table_pointer_upper;
      logic [7:0]       table_high_byte_latch;
      logic             dmem_rd;
      logic             dmem_wr;
      logic [7:0]       wdata;
      logic             pmem_rd;
      logic [PAW-1:0]   paddr;
      logic             done;
      logic             skip;
      logic             dummy;
      logic             ready;
   } eis_state_rec_t;

endpackage

// *** design/eis_alu.sv ***
// Data path of the executor: result, write enables and skip condition
`timescale 1ns/10ps
module eis_alu (
   // Operation
   input  wire eis_pkg::eis_op_t op_i,
   input  wire logic [2:0]       bsel_i,
   // Operands
   input  wire logic [7:0]       acc_i,
   input  wire logic [7:0]       mdata_i,
   // Results
   output logic                  acc_wr_o,
   output logic [7:0]            acc_val_o,
   output logic                  mem_wr_o,
   output logic [7:0]            mem_val_o,
   output logic                  z_wr_o,
   output logic                  z_val_o,
   output logic                  skip_o
);

   logic [7:0] swapped;
   logic [7:0] xored;

   assign swapped = {mdata_i[3:0], mdata_i[7:4]};
   assign xored   = acc_i ^ mdata_i;

   always_comb begin
      acc_wr_o  = 1'b0;
      acc_val_o = acc_i;
      mem_wr_o  = 1'b0;
      mem_val_o = mdata_i;
      z_wr_o    = 1'b0;
      z_val_o   = (xored == 8'h00);
      skip_o    = 1'b0;
      case (op_i)
         eis_pkg::OP_SWAP: begin
            mem_wr_o  = 1'b1;
            mem_val_o = swapped;
         end
         eis_pkg::OP_SWAPA: begin
            acc_wr_o  = 1'b1;
            acc_val_o = swapped;
         end
         eis_pkg::OP_SZ: begin
            mem_wr_o  = 1'b1;
            skip_o    = (mdata_i == 8'h00);
         end
         eis_pkg::OP_SZA: begin
            acc_wr_o  = 1'b1;
            acc_val_o = mdata_i;
            skip_o    = (mdata_i == 8'h00);
         end
         eis_pkg::OP_SZBIT: begin
            skip_o    = ~mdata_i[bsel_i];
         end
         eis_pkg::OP_XOR: begin
            acc_wr_o  = 1'b1;
            acc_val_o = xored;
            z_wr_o    = 1'b1;
         end
         eis_pkg::OP_XORM: begin
            mem_wr_o  = 1'b1;
            mem_val_o = xored;
            z_wr_o    = 1'b1;
         end
         default: begin
            skip_o    = 1'b0;
         end
      endcase
   end

endmodule

// *** design/eis_exec.sv ***
// Executor for nibble exchange, far skips, program reads and exclusive-or
`timescale 1ns/10ps
module eis_exec (
   // Clock and reset
   input  wire logic                       ref_clk_i,
   input  wire logic                       resetn_i,
   // Instruction request
   input  wire logic                       op_valid_i,
   input  wire eis_pkg::eis_op_t           op_code_i,
   input  wire logic [eis_pkg::DAW-1:0]    op_addr_i,
   input  wire logic [2:0]                 op_bit_i,
   output logic                            op_ready_o,
   // Core register loads
   input  wire logic                       ld_valid_i,
   input  wire eis_pkg::eis_ld_t           ld_sel_i,
   input  wire logic [7:0]                 ld_data_i,
   // Data memory
   output logic                            dmem_rd_o,
   output logic                            dmem_wr_o,
   output logic [eis_pkg::DAW-1:0]         dmem_addr_o,
   output logic [7:0]                      dmem_wdata_o,
   input  wire logic [7:0]                 dmem_rdata_i,
   // Program memory
   output logic                            pmem_rd_o,
   output logic [eis_pkg::PAW-1:0]         pmem_addr_o,
   input  wire logic [eis_pkg::PWW-1:0]    pmem_rdata_i,
   // Core state
   output logic [7:0]                      acc_o,
   output logic                            z_o,
   output logic [7:0]                      table_pointer_lower_o,
   output logic [7:0]                      table_pointer_upper_o,
   output logic [7:0]                      table_high_byte_latch_o,
   // Completion
   output logic                            done_o,
   output logic                            skip_o,
   output logic                            dummy_o
);

   eis_pkg::eis_state_rec_t s_q;
   eis_pkg::eis_state_rec_t s_d;

   logic       a_acc_wr;
   logic [7:0] a_acc_val;
   logic       a_mem_wr;
   logic [7:0] a_mem_val;
   logic       a_z_wr;
   logic       a_z_val;
   logic       a_skip;
   logic [7:0] ptr_next;
   logic       is_table;
   logic       is_last;
   logic       is_preinc;

   //=======================================================================
   // Data path
   eis_alu u_alu (
      .op_i      (s_q.op),
      .bsel_i    (s_q.bsel),
      .acc_i     (s_q.acc),
      .mdata_i   (dmem_rdata_i),
      .acc_wr_o  (a_acc_wr),
      .acc_val_o (a_acc_val),
      .mem_wr_o  (a_mem_wr),
      .mem_val_o (a_mem_val),
      .z_wr_o    (a_z_wr),
      .z_val_o   (a_z_val),
      .skip_o    (a_skip)
   );

   assign is_table  = (op_code_i == eis_pkg::OP_TRD)
                   || (op_code_i == eis_pkg::OP_TRDL)
                   || (op_code_i == eis_pkg::OP_ITRD)
                   || (op_code_i == eis_pkg::OP_ITRDL);
   assign is_last   = (op_code_i == eis_pkg::OP_TRDL)
                   || (op_code_i == eis_pkg::OP_ITRDL);
   assign is_preinc = (op_code_i == eis_pkg::OP_ITRD)
                   || (op_code_i == eis_pkg::OP_ITRDL);
   // Pointer wraps inside its byte; the upper pointer is never carried into
   assign ptr_next  = is_preinc ? s_q.table_pointer_lower + 8'h01 : s_q.table_pointer_lower;

   //=======================================================================
   // Sequencer
   always_comb begin
      s_d         = s_q;
      s_d.dmem_rd = 1'b0;
      s_d.dmem_wr = 1'b0;
      s_d.pmem_rd = 1'b0;
      s_d.done    = 1'b0;
      s_d.skip    = 1'b0;
      s_d.dummy   = 1'b0;
      case (s_q.st)
         eis_pkg::ST_IDLE: begin
            if (op_valid_i) begin
               s_d.op   = op_code_i;
               s_d.addr = op_addr_i;
               s_d.bsel = op_bit_i;
               if (is_table) begin
                  s_d.table_pointer_lower    = ptr_next;
                  s_d.pmem_rd = 1'b1;
                  s_d.paddr   = is_last ? {eis_pkg::LAST_PAGE, ptr_next}
                                        : {s_q.table_pointer_upper, ptr_next};
                  s_d.st      = eis_pkg::ST_PRD;
               end else begin
                  s_d.dmem_rd = 1'b1;
                  s_d.st      = eis_pkg::ST_RDM;
               end
            end else if (ld_valid_i) begin
               case (ld_sel_i)
                  eis_pkg::LD_ACC:  s_d.acc  = ld_data_i;
                  eis_pkg::LD_TABLE_POINTER_LOWER: s_d.table_pointer_lower = ld_data_i;
                  eis_pkg::LD_TABLE_POINTER_UPPER: s_d.table_pointer_upper = ld_data_i;
                  default:          s_d.acc  = s_q.acc;
               endcase
            end
         end
         eis_pkg::ST_RDM: begin
            s_d.st = eis_pkg::ST_EXE;
         end
         eis_pkg::ST_EXE: begin
            if (a_acc_wr) begin
               s_d.acc = a_acc_val;
            end
            if (a_z_wr) begin
               s_d.z = a_z_val;
            end
            s_d.dmem_wr = a_mem_wr;
            s_d.wdata   = a_mem_val;
            if (a_skip) begin
               s_d.dummy = 1'b1;
               s_d.st    = eis_pkg::ST_DUMMY;
            end else begin
               s_d.done  = 1'b1;
               s_d.st    = eis_pkg::ST_IDLE;
            end
         end
         eis_pkg::ST_DUMMY: begin
            s_d.done = 1'b1;
            s_d.skip = 1'b1;
            s_d.st   = eis_pkg::ST_IDLE;
         end
         eis_pkg::ST_PRD: begin
            s_d.st = eis_pkg::ST_PWB;
         end
         eis_pkg::ST_PWB: begin
            s_d.dmem_wr = 1'b1;
            s_d.wdata   = pmem_rdata_i[7:0];
            s_d.table_high_byte_latch    = pmem_rdata_i[15:8];
            s_d.done    = 1'b1;
            s_d.st      = eis_pkg::ST_IDLE;
         end
         default: begin
            s_d.st = eis_pkg::ST_IDLE;
         end
      endcase
      s_d.ready = (s_d.st == eis_pkg::ST_IDLE);
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         s_q       <= '0;
         s_q.st    <= eis_pkg::ST_IDLE;
         s_q.op    <= eis_pkg::OP_SWAP;
         s_q.acc   <= eis_pkg::ACC_RST;
         s_q.z     <= eis_pkg::Z_RST;
         s_q.table_pointer_lower  <= eis_pkg::PTR_RST;
         s_q.table_pointer_upper  <= eis_pkg::PTR_RST;
         s_q.table_high_byte_latch  <= eis_pkg::PTR_RST;
         s_q.ready <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   //=======================================================================
   // Outputs
   assign op_ready_o   = s_q.ready;
   assign dmem_rd_o    = s_q.dmem_rd;
   assign dmem_wr_o    = s_q.dmem_wr;
   assign dmem_addr_o  = s_q.addr;
   assign dmem_wdata_o = s_q.wdata;
   assign pmem_rd_o    = s_q.pmem_rd;
   assign pmem_addr_o  = s_q.paddr;
   assign acc_o        = s_q.acc;
   assign z_o          = s_q.z;
   assign table_pointer_lower_o       = s_q.table_pointer_lower;
   assign table_pointer_upper_o       = s_q.table_pointer_upper;
   assign table_high_byte_latch_o       = s_q.table_high_byte_latch;
   assign done_o       = s_q.done;
   assign skip_o       = s_q.skip;
   assign dummy_o      = s_q.dummy;

   //=======================================================================
   // Checks
   logic [7:0] chk_swap;
   logic [7:0] chk_xor;
   logic       chk_exe;
   logic       chk_bit;
   logic       chk_take;

   assign chk_swap = {dmem_rdata_i[3:0], dmem_rdata_i[7:4]};
   assign chk_xor  = s_q.acc ^ dmem_rdata_i;
   assign chk_exe  = (s_q.st == eis_pkg::ST_EXE);
   assign chk_bit  = dmem_rdata_i[s_q.bsel];
   assign chk_take = op_valid_i && s_q.ready && is_preinc;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   swap_mem_a: assert property (
      chk_exe && s_q.op == eis_pkg::OP_SWAP |=> dmem_wr_o
      && dmem_wdata_o == $past(chk_swap) && z_o == $past(z_o))
      else $error("in-place nibble exchange wrong");
   swap_acc_a: assert property (
      chk_exe && s_q.op == eis_pkg::OP_SWAPA |=> !dmem_wr_o
      && acc_o == $past(chk_swap))
      else $error("nibble exchange to accumulator wrong");
   sz_write_a: assert property (
      chk_exe && s_q.op == eis_pkg::OP_SZ |=> dmem_wr_o
      && dmem_wdata_o == $past(dmem_rdata_i))
      else $error("skip byte not written back");
   skip_slot_a: assert property (
      chk_exe && a_skip |=> dummy_o && !done_o ##1 done_o && skip_o)
      else $error("taken skip lacks dummy slot");
   sza_copy_a: assert property (
      chk_exe && s_q.op == eis_pkg::OP_SZA |=> acc_o == $past(dmem_rdata_i)
      ##1 (skip_o == ($past(acc_o, 1) == 8'h00)))
      else $error("copy and skip wrong");
   bit_skip_a: assert property (
      chk_exe && s_q.op == eis_pkg::OP_SZBIT && chk_bit
      |=> done_o && !skip_o && !dummy_o)
      else $error("set bit caused a skip");
   page_addr_a: assert property (
      s_q.st == eis_pkg::ST_PRD && s_q.op == eis_pkg::OP_TRD
      |-> pmem_addr_o == {table_pointer_upper_o, table_pointer_lower_o}
      ##2 table_high_byte_latch_o == $past(pmem_rdata_i[15:8]))
      else $error("paged program read address wrong");
   last_addr_a: assert property (
      s_q.st == eis_pkg::ST_PRD && s_q.op == eis_pkg::OP_TRDL
      |-> pmem_addr_o == {eis_pkg::LAST_PAGE, table_pointer_lower_o})
      else $error("final page read address wrong");
   preinc_a: assert property (
      chk_take |=> table_pointer_lower_o == $past(table_pointer_lower_o) + 8'h01 && pmem_rd_o
      && pmem_addr_o[7:0] == table_pointer_lower_o)
      else $error("pointer not incremented before read");
   xor_acc_a: assert property (
      chk_exe && s_q.op == eis_pkg::OP_XOR |=> acc_o == $past(chk_xor)
      && z_o == (acc_o == 8'h00) && !dmem_wr_o)
      else $error("exclusive-or into accumulator wrong");
   xor_mem_a: assert property (
      chk_exe && s_q.op == eis_pkg::OP_XORM |=> dmem_wr_o
      && dmem_wdata_o == $past(chk_xor) && z_o == (dmem_wdata_o == 8'h00))
      else $error("exclusive-or into memory wrong");
   noskip_a: assert property (
      chk_exe && !a_skip |=> done_o && !dummy_o && op_ready_o)
      else $error("untaken skip not two cycles");

   skip_taken_c: cover property (chk_exe && a_skip ##2 skip_o);
   table_read_c: cover property (s_q.st == eis_pkg::ST_PWB ##1 done_o);
   xor_zero_c:   cover property (chk_exe && a_z_wr && a_z_val);
   back_back_c:  cover property (done_o && op_valid_i ##3 done_o);

endmodule

// *** sim/eis_exec_test.sv ***
// Self-checking bench for the extended instruction executor
`timescale 1ns/10ps
module eis_exec_test;

   //=======================================================================
   // Design inputs and outputs
   logic                    ref_clk_i;
   logic                    resetn_i;
   logic                    op_valid_i;
   eis_pkg::eis_op_t        op_code_i;
   logic [eis_pkg::DAW-1:0] op_addr_i;
   logic [2:0]              op_bit_i;
   logic                    op_ready_o;
   logic                    ld_valid_i;
   eis_pkg::eis_ld_t        ld_sel_i;
   logic [7:0]              ld_data_i;
   logic                    dmem_rd_o;
   logic                    dmem_wr_o;
   logic [eis_pkg::DAW-1:0] dmem_addr_o;
   logic [7:0]              dmem_wdata_o;
   logic [7:0]              dmem_rdata_i = 8'h00;
   logic                    pmem_rd_o;
   logic [eis_pkg::PAW-1:0] pmem_addr_o;
   logic [eis_pkg::PWW-1:0] pmem_rdata_i = 16'h0000;
   logic [7:0]              acc_o;
   logic                    z_o;
   logic [7:0]              table_pointer_lower_o;
   logic [7:0]              table_pointer_upper_o;
   logic [7:0]              table_high_byte_latch_o;
   logic                    done_o;
   logic                    skip_o;
   logic                    dummy_o;

   //=======================================================================
   // Bench state
   typedef struct {
      eis_pkg::eis_op_t op;
      logic [11:0]      a;
      logic [2:0]       b;
      logic [7:0]       acc;
      logic [7:0]       m;
      logic [7:0]       e_acc;
      logic [7:0]       e_m;
      logic [2:0]       fl;
   } eis_row_t;

   // Flags column: write expected, zero flag after, skip taken
   eis_row_t   rows [15] = '{
      '{eis_pkg::OP_XOR,   12'h001, 3'h0, 8'h3c, 8'h3c, 8'h00, 8'h3c, 3'h2},
      '{eis_pkg::OP_SWAP,  12'h002, 3'h0, 8'h00, 8'h12, 8'h00, 8'h21, 3'h6},
      '{eis_pkg::OP_SWAPA, 12'h003, 3'h0, 8'h00, 8'hc7, 8'h7c, 8'hc7, 3'h2},
      '{eis_pkg::OP_SZ,    12'h004, 3'h0, 8'h11, 8'h00, 8'h11, 8'h00, 3'h7},
      '{eis_pkg::OP_SZ,    12'h005, 3'h0, 8'h11, 8'h80, 8'h11, 8'h80, 3'h6},
      '{eis_pkg::OP_SZA,   12'h006, 3'h0, 8'hff, 8'h00, 8'h00, 8'h00, 3'h3},
      '{eis_pkg::OP_SZA,   12'h007, 3'h0, 8'h00, 8'h01, 8'h01, 8'h01, 3'h2},
      '{eis_pkg::OP_SZBIT, 12'h008, 3'h7, 8'h00, 8'h7f, 8'h00, 8'h7f, 3'h3},
      '{eis_pkg::OP_SZBIT, 12'h009, 3'h0, 8'h00, 8'h01, 8'h00, 8'h01, 3'h2},
      '{eis_pkg::OP_SZBIT, 12'h00a, 3'h3, 8'h00, 8'hf7, 8'h00, 8'hf7, 3'h3},
      '{eis_pkg::OP_XORM,  12'hfff, 3'h0, 8'h0f, 8'hf0, 8'h0f, 8'hff, 3'h4},
      '{eis_pkg::OP_XOR,   12'h00c, 3'h0, 8'h55, 8'h0f, 8'h5a, 8'h0f, 3'h0},
      '{eis_pkg::OP_SZ,    12'h00d, 3'h0, 8'h5a, 8'h00, 8'h5a, 8'h00, 3'h5},
      '{eis_pkg::OP_SZBIT, 12'h00e, 3'h4, 8'h5a, 8'h10, 8'h5a, 8'h10, 3'h0},
      '{eis_pkg::OP_XORM,  12'h000, 3'h0, 8'haa, 8'haa, 8'haa, 8'h00, 3'h6}
   };
   logic [7:0]  mem [0:4095];
   logic [15:0] pa;
   logic [15:0] w;
   logic        sk;
   logic        dm;
   int          n_cyc;
   int          n_wr;
   int          n_fail;
   int          n_checks;

   eis_exec i_eis_exec (.*);

   //=======================================================================
   // Clock, memories and watchdog
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end

   // Program words are a fixed scramble of their address
   function automatic logic [15:0] pw(input logic [15:0] a);
      return {a[7:0] ^ 8'h96, a[15:8] ^ 8'h3c};
   endfunction

   // Idle read buses show the inverse of their last value, never a hold
   always @(posedge ref_clk_i) begin
      if (dmem_wr_o === 1'b1) mem[dmem_addr_o] <= dmem_wdata_o;
      dmem_rdata_i <= (dmem_rd_o === 1'b1) ? mem[dmem_addr_o] : ~dmem_rdata_i;
      pmem_rdata_i <= (pmem_rd_o === 1'b1) ? pw(pmem_addr_o) : ~pmem_rdata_i;
   end

   initial begin
      repeat (20000) @(posedge ref_clk_i);
      n_fail++;
      report_and_stop();
   end

   //=======================================================================
   // Tasks
   task automatic chk(input string nm, input logic [15:0] s, e);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic load(input eis_pkg::eis_ld_t s, input logic [7:0] d);
      @(negedge ref_clk_i);
      ld_valid_i = 1'b1;
      ld_sel_i = s;
      ld_data_i = d;
      @(negedge ref_clk_i);
      ld_valid_i = 1'b0;
   endtask

   // Ready is high here since the previous op finished edges ago
   task automatic run_op(input eis_pkg::eis_op_t op, input logic [11:0] a,
                         input logic [2:0] b);
      @(negedge ref_clk_i);
      op_valid_i = 1'b1;
      op_code_i = op;
      op_addr_i = a;
      op_bit_i = b;
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      op_valid_i = 1'b0;
      n_cyc = 0;
      n_wr = 0;
      dm = 1'b0;
      sk = 1'bx;
      pa = 16'hxxxx;
      // Program read strobe stands only in the cycle after acceptance
      if (pmem_rd_o === 1'b1) pa = pmem_addr_o;
      while (n_cyc < 10) begin
         @(posedge ref_clk_i);
         #1;
         n_cyc++;
         if (dmem_wr_o === 1'b1) n_wr++;
         if (dummy_o === 1'b1) dm = 1'b1;
         if (pmem_rd_o === 1'b1) pa = pmem_addr_o;
         if (done_o === 1'b1) begin
            sk = skip_o;
            break;
         end
      end
      // One more edge lets the bench memory take the write
      @(posedge ref_clk_i);
      #1;
   endtask

   task automatic tbl(input eis_pkg::eis_op_t op, input logic [15:0] ea);
      w = pw(ea);
      run_op(op, 12'h200, 3'h0);
      chk("program address", pa, ea);
      chk("lower pointer", table_pointer_lower_o, ea[7:0]);
      chk("memory low byte", mem[12'h200], w[7:0]);
      chk("high latch", table_high_byte_latch_o, w[15:8]);
      chk("upper pointer", table_pointer_upper_o, 16'h0012);
      chk("zero flag", z_o, 16'h0001);
      chk("cycles", 16'(n_cyc), 16'h0002);
      $display("table read test done at %h", ea);
   endtask

   task automatic chk_rst();
      chk("ready", op_ready_o, 16'h0001);
      chk("accumulator", acc_o, 16'h0000);
      chk("zero flag", z_o, 16'h0000);
      chk("lower pointer", table_pointer_lower_o, 16'h0000);
      chk("upper pointer", table_pointer_upper_o, 16'h0000);
      chk("high latch", table_high_byte_latch_o, 16'h0000);
      chk("done", done_o, 16'h0000);
      chk("memory write", dmem_wr_o, 16'h0000);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   //=======================================================================
   // Main sequence
   initial begin
      resetn_i = 1'b0;
      op_valid_i = 1'b0;
      op_code_i = eis_pkg::OP_SWAP;
      op_addr_i = 12'h000;
      op_bit_i = 3'h0;
      ld_valid_i = 1'b0;
      ld_sel_i = eis_pkg::LD_ACC;
      ld_data_i = 8'h00;
      repeat (3) @(negedge ref_clk_i);
      resetn_i = 1'b1;
      #1;
      chk_rst();
      $display("reset test done");
      foreach (rows[i]) begin
         load(eis_pkg::LD_ACC, rows[i].acc);
         mem[rows[i].a] = rows[i].m;
         run_op(rows[i].op, rows[i].a, rows[i].b);
         chk("accumulator", acc_o, rows[i].e_acc);
         chk("memory", mem[rows[i].a], rows[i].e_m);
         chk("zero flag", z_o, rows[i].fl[1]);
         chk("writes", 16'(n_wr), rows[i].fl[2]);
         chk("skip", sk, rows[i].fl[0]);
         chk("dummy slot", dm, rows[i].fl[0]);
         chk("cycles", 16'(n_cyc), 16'h2 + rows[i].fl[0]);
         $display("row test %0d done", i);
      end
      load(eis_pkg::LD_TABLE_POINTER_UPPER, 8'h12);
      load(eis_pkg::LD_TABLE_POINTER_LOWER, 8'hff);
      tbl(eis_pkg::OP_TRD, 16'h12ff);
      tbl(eis_pkg::OP_TRDL, 16'hffff);
      tbl(eis_pkg::OP_ITRD, 16'h1200);
      tbl(eis_pkg::OP_ITRDL, 16'hff01);
      // Reset lands while a skip is in flight
      @(negedge ref_clk_i);
      op_valid_i = 1'b1;
      op_code_i = eis_pkg::OP_SZ;
      @(negedge ref_clk_i);
      op_valid_i = 1'b0;
      resetn_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      chk_rst();
      resetn_i = 1'b1;
      $display("mid-run reset test done");
      // The cut skip must leave nothing behind for the next instruction
      run_op(eis_pkg::OP_SWAPA, 12'h200, 3'h0);
      chk("accumulator", acc_o, 16'h003c);
      chk("memory", mem[12'h200], 16'h00c3);
      chk("cycles", 16'(n_cyc), 16'h0002);
      $display("run after reset test done");
      report_and_stop();
   end

endmodule
